/* File: logic_blocks.v */
// safety logic function blocks: gates, delay, pulse, start latch, lookup table
//
// Notes on behaviour
// R1 - and output high only while every enabled input is present
// R2 - on-delay: output rises after input held for the delay length
// R3 - off-delay: output falls only after delay length since input removal
// R4 - delay block has one type bit and one delay length
// R5 - nor output high only while no enabled input is present
// R6 - or output high while at least one enabled input is present
// R7 - pulse rises on input falling edge, lasts exactly pulse length; code ends it on the pulse-length-th tick, so up to one tick short
// R8 - start output sets on selected control edge while enable input present
// R9 - start output holds while enable present, drops when it is removed
// R10 - edge select picks rising or falling control edge
// R11 - lookup output is the mapped entry, zero after reset
// R12 - entry count setting limits conversion to stored entries
// R13 - times counted in ticks; count restarts when trigger condition changes
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
`include "logic_blocks_defs.vh"
module logic_blocks (
    input  wire                     ref_clk,
    input  wire                     arst_n,
    input  wire [`ADDR_W-1:0]       reg_addr,
    input  wire [31:0]              reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [31:0]              reg_rdata,
    input  wire [`GATE_INPUTS-1:0]  gate_in,
    output reg                      and_out,
    output reg                      or_out,
    output reg                      nor_out,
    input  wire                     delay_in,
    output reg                      delay_out,
    input  wire                     pulse_in,
    output reg                      pulse_out,
    input  wire                     start_enable_in,
    input  wire                     start_control_in,
    output reg                      start_out,
    input  wire [`DATA_W-1:0]       convert_in,
    input  wire                     convert_valid,
    output reg  [`DATA_W-1:0]       converted_value_out,
    output reg                      convert_miss
);

    // three-stage synchronisers for pin inputs; change accepted when stages 2 and 3 agree
    localparam SYNC_W = `GATE_INPUTS + 4;
    wire [SYNC_W-1:0] raw_in = {start_control_in, start_enable_in, pulse_in, delay_in, gate_in};
    reg  [SYNC_W-1:0] sync1_r;
    reg  [SYNC_W-1:0] sync2_r;
    reg  [SYNC_W-1:0] sync3_r;
    reg  [SYNC_W-1:0] clean_r;
    reg  [SYNC_W-1:0] clean_nxt;
    integer i;

    always @* begin
        clean_nxt = clean_r;
        for (i = 0; i < SYNC_W; i = i + 1) begin
            if (sync2_r[i] == sync3_r[i]) begin
                clean_nxt[i] = sync2_r[i];
            end
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= {SYNC_W{1'b0}};
            sync2_r <= {SYNC_W{1'b0}};
            sync3_r <= {SYNC_W{1'b0}};
            clean_r <= {SYNC_W{1'b0}};
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            clean_r <= clean_nxt;
        end
    end

    wire [`GATE_INPUTS-1:0] gate_s = clean_r[`GATE_INPUTS-1:0];
    wire delay_s   = clean_r[`GATE_INPUTS];
    wire pulse_s   = clean_r[`GATE_INPUTS+1];
    wire enable_s  = clean_r[`GATE_INPUTS+2];
    wire control_s = clean_r[`GATE_INPUTS+3];

    // configuration registers
    reg [`GATE_INPUTS-1:0] and_mask_r;
    reg [`GATE_INPUTS-1:0] or_mask_r;
    reg [`GATE_INPUTS-1:0] nor_mask_r;
    reg                    delay_type_r;
    reg [`TIME_W-1:0]      delay_length_r;
    reg [`TIME_W-1:0]      pulse_length_r;
    reg                    trigger_sel_r;
    reg [`TBL_CNT_W-1:0]   table_count_r;
    reg [`DATA_W-1:0]      key_mem [0:`TBL_DEPTH-1];
    reg [`DATA_W-1:0]      val_mem [0:`TBL_DEPTH-1];

    // tick timebase shared by delay and pulse timers
    reg [`TICK_CNT_W-1:0] tick_cnt_r;
    reg                   tick_r;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_r <= `TICK_CNT_ZERO;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == `TICK_CNT_LAST) begin
            tick_cnt_r <= `TICK_CNT_ZERO;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 8'h01;
            tick_r     <= 1'b0;
        end
    end

    // gate blocks; an empty mask leaves and/or low and nor high
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            and_out <= 1'b0;
            or_out  <= 1'b0;
            nor_out <= 1'b0;
        end else begin
            // R1 all inputs present
            and_out <= (and_mask_r != 8'h00) && ((gate_s & and_mask_r) == and_mask_r);
            // R6 any input present
            or_out  <= |(gate_s & or_mask_r);
            // R5 no input present
            nor_out <= ~|(gate_s & nor_mask_r);
        end
    end

    // delay block
    reg [`TIME_W-1:0] delay_cnt_r;
    reg               delay_prev_r;
    wire              delay_target = (delay_type_r == `DELAY_TYPE_ON) ? delay_s : ~delay_s;
    // one extra tick absorbs the partial first tick, so the delay is never short, except at length 16'hFFFF where the limit wraps to zero
    wire [`TIME_W-1:0] delay_limit = delay_length_r + `TIME_ONE;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            delay_cnt_r  <= `TIME_ZERO;
            delay_prev_r <= 1'b0;
            delay_out    <= 1'b0;
        end else begin
            delay_prev_r <= delay_s;
            // R13 restart on input change
            if (delay_s != delay_prev_r) begin
                delay_cnt_r <= `TIME_ZERO;
            end else if (tick_r && delay_target && delay_cnt_r != delay_limit) begin
                delay_cnt_r <= delay_cnt_r + `TIME_ONE;
            end
            // R4 type picks delayed edge
            if (delay_type_r == `DELAY_TYPE_ON) begin
                // R2 rise after held time
                if (!delay_s) begin
                    delay_out <= 1'b0;
                end else if (delay_s == delay_prev_r && delay_cnt_r == delay_limit) begin
                    delay_out <= 1'b1;
                end
            end else begin
                // R3 fall after removal time
                if (delay_s) begin
                    delay_out <= 1'b1;
                end else if (delay_s == delay_prev_r && delay_cnt_r == delay_limit) begin
                    delay_out <= 1'b0;
                end
            end
        end
    end

    // pulse block
    reg [`TIME_W-1:0] pulse_cnt_r;
    reg               pulse_prev_r;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_cnt_r  <= `TIME_ZERO;
            pulse_prev_r <= 1'b0;
            pulse_out    <= 1'b0;
        end else begin
            pulse_prev_r <= pulse_s;
            // R7 falling edge starts pulse
            if (pulse_prev_r && !pulse_s) begin
                // R13 count restarts on trigger
                pulse_cnt_r <= `TIME_ZERO;
                pulse_out   <= (pulse_length_r != `TIME_ZERO);
            end else if (pulse_out && tick_r) begin
                // R7 end after pulse length
                if (pulse_cnt_r + `TIME_ONE >= pulse_length_r) begin
                    pulse_out <= 1'b0;
                end
                pulse_cnt_r <= pulse_cnt_r + `TIME_ONE;
            end
        end
    end

    // start latch
    reg  control_prev_r;
    wire control_edge = (trigger_sel_r == `TRIG_RISING) ? (control_s && !control_prev_r)
                                                        : (!control_s && control_prev_r);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            control_prev_r <= 1'b0;
            start_out      <= 1'b0;
        end else begin
            control_prev_r <= control_s;
            // R9 drop when enable removed
            if (!enable_s) begin
                start_out <= 1'b0;
            // R8 R10 selected edge sets
            end else if (control_edge) begin
                start_out <= 1'b1;
            end
        end
    end

    // lookup table: search stored keys, first match wins
    reg              hit;
    reg [`DATA_W-1:0] hit_val;
    integer k;

    always @* begin
        hit     = 1'b0;
        hit_val = `DATA_ZERO;
        for (k = `TBL_DEPTH - 1; k >= 0; k = k - 1) begin
            // R12 only configured entries
            if (k < table_count_r && key_mem[k] == convert_in) begin
                hit     = 1'b1;
                hit_val = val_mem[k];
            end
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            // R11 zero after reset
            converted_value_out <= `DATA_ZERO;
            convert_miss        <= 1'b0;
        end else if (convert_valid) begin
            // R11 mapped entry out
            if (hit) begin
                converted_value_out <= hit_val;
            end
            convert_miss <= ~hit;
        end
    end

    // register writes
    wire tbl_sel = (reg_addr & `REG_TBL_MASK) == `REG_TBL_BASE;
    wire [`TBL_IDX_W-1:0] tbl_idx = reg_addr[`TBL_IDX_W+1:2];

    always @(posedge ref_clk) begin
        if (reg_wr && tbl_sel) begin
            key_mem[tbl_idx] <= reg_wdata[`DATA_W-1:0];
            val_mem[tbl_idx] <= reg_wdata[`DATA_W+7:8];
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            and_mask_r     <= 8'h00;
            or_mask_r      <= 8'h00;
            nor_mask_r     <= 8'h00;
            delay_type_r   <= `DELAY_TYPE_ON;
            delay_length_r <= `TIME_ZERO;
            pulse_length_r <= `TIME_ZERO;
            trigger_sel_r  <= `TRIG_RISING;
            table_count_r  <= `TBL_CNT_ZERO;
        end else if (reg_wr) begin
            case (reg_addr)
                `REG_LOGIC_CFG: begin
                    and_mask_r <= reg_wdata[7:0];
                    or_mask_r  <= reg_wdata[15:8];
                    nor_mask_r <= reg_wdata[23:16];
                end
                `REG_DELAY_CFG: begin
                    delay_length_r <= reg_wdata[15:0];
                    delay_type_r   <= reg_wdata[16];
                end
                `REG_PULSE_CFG: begin
                    pulse_length_r <= reg_wdata[15:0];
                    trigger_sel_r  <= reg_wdata[16];
                end
                `REG_TBL_CFG: begin
                    if (reg_wdata[`TBL_CNT_W-1:0] > 5'h10) begin
                        table_count_r <= 5'h10;
                    end else begin
                        table_count_r <= reg_wdata[`TBL_CNT_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // register reads, data one cycle after the strobe
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            if (tbl_sel) begin
                reg_rdata <= {16'h0000, val_mem[tbl_idx], key_mem[tbl_idx]};
            end else begin
                case (reg_addr)
                    `REG_LOGIC_CFG: reg_rdata <= {8'h00, nor_mask_r, or_mask_r, and_mask_r};
                    `REG_DELAY_CFG: reg_rdata <= {15'h0000, delay_type_r, delay_length_r};
                    `REG_PULSE_CFG: reg_rdata <= {15'h0000, trigger_sel_r, pulse_length_r};
                    `REG_TBL_CFG:   reg_rdata <= {27'h0000000, table_count_r};
                    `REG_STATUS:    reg_rdata <= {8'h00, converted_value_out, gate_s,
                                                  1'b0, convert_miss, start_out, pulse_out,
                                                  delay_out, nor_out, or_out, and_out};
                    default:        reg_rdata <= 32'h00000000;
                endcase
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule // logic_blocks

/* File: logic_blocks_defs.vh */
// constants for the safety logic function blocks
`ifndef LOGIC_BLOCKS_DEFS_VH
`define LOGIC_BLOCKS_DEFS_VH
`define GATE_INPUTS      8
`define TIME_W           16
`define TICK_NS          1000
`define CLK_NS           8
`define TICK_CYCLES      ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`define TICK_CNT_W       8
`define TICK_CNT_ZERO    8'h00
`define TICK_CNT_LAST    8'h7C
`define TIME_ZERO        16'h0000
`define TIME_ONE         16'h0001
`define DATA_W           8
`define DATA_ZERO        8'h00
`define TBL_DEPTH        16
`define TBL_IDX_W        4
`define TBL_CNT_W        5
`define TBL_CNT_ZERO     5'h00
`define ADDR_W           8
`define DELAY_TYPE_ON    1'b0
`define DELAY_TYPE_OFF   1'b1
`define TRIG_RISING      1'b0
`define TRIG_FALLING     1'b1
`define REG_LOGIC_CFG    8'h00
`define REG_DELAY_CFG    8'h04
`define REG_PULSE_CFG    8'h08
`define REG_TBL_CFG      8'h0C
`define REG_STATUS       8'h10
`define REG_TBL_BASE     8'h40
`define REG_TBL_MASK     8'hC0
`endif

/* File: logic_blocks_chk.sv */
// assertion checker for the safety logic function blocks
`timescale 1ns/1ns
module logic_blocks_chk (
    input logic        ref_clk,
    input logic        arst_n,
    input logic [7:0]  reg_addr,
    input logic [31:0] reg_wdata,
    input logic        reg_wr,
    input logic [7:0]  gate_in,
    input logic        and_out,
    input logic        or_out,
    input logic        nor_out,
    input logic        delay_in,
    input logic        delay_out,
    input logic        pulse_in,
    input logic        pulse_out,
    input logic        start_enable_in,
    input logic        start_out,
    input logic        convert_valid,
    input logic [7:0]  converted_value_out
);
    logic [23:0] m_r;
    logic [16:0] cfg_r;
    logic [3:0]  gq_r;
    logic [31:0] ds_r;
    logic [7:0]  fc_r;
    wire  [31:0] dmin = {16'h0000, cfg_r[15:0]} * 32'h0000007D;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // gq_r counts quiet cycles on gates and register writes, so sync latency has passed
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            m_r   <= 24'h000000;
            cfg_r <= 17'h00000;
            gq_r  <= 4'h0;
            ds_r  <= 32'h00000000;
            fc_r  <= 8'hFF;
        end else begin
            if (reg_wr && reg_addr == 8'h00) m_r <= reg_wdata[23:0];
            if (reg_wr && reg_addr == 8'h04) cfg_r <= reg_wdata[16:0];
            gq_r <= ($changed(gate_in) || reg_wr) ? 4'h0 : gq_r + {3'h0, gq_r != 4'hF};
            ds_r <= $changed(delay_in) ? 32'h00000000 : ds_r + 32'h00000001;
            fc_r <= $fell(pulse_in) ? 8'h00 : fc_r + {7'h00, fc_r != 8'hFF};
        end
    end
    a_and_level: assert property (gq_r == 4'hF |-> and_out ==
        (m_r[7:0] != 8'h00 && (gate_in & m_r[7:0]) == m_r[7:0])) else $error("and output wrong");
    a_or_level: assert property (gq_r == 4'hF |-> or_out == |(gate_in & m_r[15:8]))
        else $error("or output wrong");
    a_nor_level: assert property (gq_r == 4'hF |-> nor_out == !(|(gate_in & m_r[23:16])))
        else $error("nor output wrong");
    a_on_delay: assert property ($rose(delay_out) && !cfg_r[16] |-> ds_r >= dmin)
        else $error("on-delay too short");
    a_off_delay: assert property ($fell(delay_out) && cfg_r[16] |-> ds_r >= dmin)
        else $error("off-delay too short");
    a_start_drop: assert property ((!start_enable_in)[*8] |-> !start_out)
        else $error("start held without enable");
    a_conv_cause: assert property ($changed(converted_value_out) |-> $past(convert_valid))
        else $error("lookup output changed unasked");
    a_pulse_cause: assert property ($rose(pulse_out) |-> fc_r <= 8'h08)
        else $error("pulse without falling input");
endmodule // logic_blocks_chk
bind logic_blocks logic_blocks_chk chk_u (.*);

/* File: sensor_src.sv */
// upstream sensor stand-in driving the block's pin inputs
`timescale 1ns/1ns
module sensor_src (
    input  logic        ref_clk,
    input  logic [11:0] lvl,
    output logic [7:0]  gate_in,
    output logic        delay_in,
    output logic        pulse_in,
    output logic        start_enable_in,
    output logic        start_control_in
);
    initial {start_control_in, start_enable_in, pulse_in, delay_in, gate_in} = 12'h000;
    // pins move only just after an edge, like a clocked monitor
    always @(posedge ref_clk) begin
        {start_control_in, start_enable_in, pulse_in, delay_in, gate_in} <= lvl;
    end
endmodule // sensor_src

/* File: logic_blocks_tb.sv */
// self-checking testbench for the safety logic function blocks
`timescale 1ns/1ns
module logic_blocks_tb;
    logic        ref_clk, arst_n, reg_wr, reg_rd, convert_valid, convert_miss;
    logic [7:0]  reg_addr, gate_in, convert_in, converted_value_out;
    logic [31:0] reg_wdata, reg_rdata;
    logic [11:0] lvl;
    logic        delay_in, pulse_in, start_enable_in, start_control_in;
    logic        and_out, or_out, nor_out, delay_out, pulse_out, start_out;
    int          n_fail, n_compared;

    logic_blocks dut_u (.*);
    sensor_src   src_u (.*);

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pin(input int i, input logic v);
        @(posedge ref_clk);
        lvl[i] <= v;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask
    task automatic conv(input logic [7:0] v, input logic [7:0] ev, input logic em);
        @(posedge ref_clk);
        convert_in <= v;
        convert_valid <= 1'b1;
        @(posedge ref_clk);
        convert_valid <= 1'b0;
        cyc(2);
        chk("lookup value", {24'h0, ev}, {24'h0, converted_value_out});
        chk1("lookup miss", em, convert_miss);
    endtask
    task automatic t_reset;
        chk1("lookup idle", 1'b0, |converted_value_out);
        rd(8'h10, 32'h00000004, "status");
        rd(8'h20, 32'h00000000, "unmapped");
        wr(8'h0C, 32'h00000014);
        rd(8'h0C, 32'h00000010, "entry count");
    endtask
    task automatic t_gates;
        logic [7:0] p[5] = '{8'h0F, 8'h07, 8'h00, 8'h30, 8'hFF};
        wr(8'h00, 32'h0030F00F);
        foreach (p[i]) begin
            @(posedge ref_clk);
            lvl[7:0] <= p[i];
            cyc(12);
            chk1("and", (p[i] & 8'h0F) == 8'h0F, and_out);
            chk1("or", |(p[i] & 8'hF0), or_out);
            chk1("nor", !(|(p[i] & 8'h30)), nor_out);
        end
    endtask
    task automatic t_delay(input logic ty);
        wr(8'h04, {15'h0000, ty, 16'h0002});
        pin(8, 1'b1);
        cyc(200);
        chk1("delay early", ty, delay_out);
        cyc(200);
        chk1("delay set", 1'b1, delay_out);
        pin(8, 1'b0);
        cyc(200);
        chk1("delay kept", ty, delay_out);
        cyc(200);
        chk1("delay clear", 1'b0, delay_out);
    endtask
    task automatic t_pulse;
        int w;
        wr(8'h08, 32'h00000003);
        pin(9, 1'b1);
        cyc(12);
        chk1("pulse on rise", 1'b0, pulse_out);
        pin(9, 1'b0);
        cyc(8);
        chk1("pulse begin", 1'b1, pulse_out);
        for (w = 0; pulse_out === 1'b1 && w < 1000; w++) cyc(1);
        chk1("pulse width", 1'b1, w >= 240 && w <= 375);
    endtask
    task automatic t_start(input logic e);
        wr(8'h08, {15'h0000, e, 16'h0003});
        pin(11, !e);
        cyc(12);
        chk1("start unarmed", 1'b0, start_out);
        pin(10, 1'b1);
        cyc(12);
        pin(11, e);
        cyc(12);
        chk1("start other edge", 1'b0, start_out);
        pin(11, !e);
        cyc(12);
        chk1("start set", 1'b1, start_out);
        pin(10, 1'b0);
        cyc(12);
        chk1("start drop", 1'b0, start_out);
    endtask
    task automatic t_lookup;
        wr(8'h0C, 32'h00000002);
        wr(8'h40, 32'h0000A511);
        wr(8'h44, 32'h00005A22);
        wr(8'h48, 32'h00007733);
        conv(8'h22, 8'h5A, 1'b0);
        conv(8'h33, 8'h5A, 1'b1);
        conv(8'h11, 8'hA5, 1'b0);
    endtask
    initial begin
        n_fail = 0;
        n_compared = 0;
        arst_n = 1'b0;
        lvl = 12'h000;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 42'h0;
        {convert_in, convert_valid} = 9'h000;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        cyc(8);
        t_reset;
        t_gates;
        t_delay(1'b0);
        t_delay(1'b1);
        t_pulse;
        t_start(1'b0);
        t_start(1'b1);
        t_lookup;
        stop_test;
    end
    initial begin
        #400000;
        n_fail++;
        stop_test;
    end
endmodule // logic_blocks_tb
